// *** logic/arf_pkg.sv ***
// Package for the API response framer: frame bytes, codes, registers.
// Assumes an APB master and a byte-wide serial transmitter downstream.
`default_nettype none
package arf_pkg;
	// ----------------------------------------
	// Frame constants
	// ----------------------------------------
	localparam logic [7:0] ARF_DELIM = 8'h7E;
	localparam logic [7:0] ARF_CKSUM_BASE = 8'hFF;
	localparam logic [7:0] ARF_TYPE_CMDRSP = 8'h88;
	localparam logic [7:0] ARF_TYPE_MODEM = 8'h8A;
	localparam logic [7:0] ARF_TYPE_TXSTAT = 8'h8B;
	localparam logic [7:0] ARF_ST_HWRESET = 8'h00;
	localparam logic [7:0] ARF_ST_WDRESET = 8'h01;
	localparam logic [7:0] ARF_ST_JOINED = 8'h02;
	localparam logic [7:0] ARF_ST_DISASSOC = 8'h03;
	localparam logic [7:0] ARF_ST_COORD = 8'h06;
	localparam logic [7:0] ARF_ST_KEYUPD = 8'h07;
	localparam logic [7:0] ARF_ST_SUPPLY = 8'h0D;
	localparam logic [7:0] ARF_ST_CFGJOIN = 8'h11;
	localparam logic [7:0] ARF_ST_STACK = 8'h80;
	localparam logic [7:0] ARF_RES_OK = 8'h00;
	localparam logic [7:0] ARF_RES_ERR = 8'h01;
	localparam logic [7:0] ARF_RES_BADCMD = 8'h02;
	localparam logic [7:0] ARF_RES_BADPAR = 8'h03;
	localparam logic [7:0] ARF_RES_TXFAIL = 8'h04;
	localparam logic [7:0] ARF_HOPS_MAX = 8'h28;
	localparam int ARF_DATA_MAX = 8;
	// Body bytes ahead of the data: type, id, two name chars, result
	localparam logic [7:0] ARF_CMD_HDR = 8'h05;
	localparam logic [7:0] ARF_MODEM_LEN = 8'h02;
	localparam logic [7:0] ARF_TXST_LEN = 8'h02;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ARF_A_CTRL = 8'h00;
	localparam logic [7:0] ARF_A_CMD = 8'h04;
	localparam logic [7:0] ARF_A_DATALO = 8'h08;
	localparam logic [7:0] ARF_A_DATAHI = 8'h0C;
	localparam logic [7:0] ARF_A_EVENT = 8'h10;
	localparam logic [7:0] ARF_A_STATUS = 8'h14;
	localparam logic [7:0] ARF_A_IRQ = 8'h18;
	localparam logic [7:0] ARF_A_MASK = 8'h1C;
	localparam logic [7:0] ARF_A_ROUTE = 8'h20;
	localparam logic [3:0] ARF_IRQ_RESET = 4'h0;
	localparam logic [3:0] ARF_MASK_RESET = 4'h0;
	// Irq bits: 0 frame sent, 1 frame suppressed, 2 bad hop count, 3 busy
	localparam int ARF_IRQ_W = 4;

	typedef enum {ARF_IDLE, ARF_DELIMS, ARF_LENH, ARF_LENL, ARF_BODY,
		ARF_CKS} arf_phase_t;

	typedef enum logic [1:0] {ARF_K_CMD, ARF_K_MODEM, ARF_K_TXST}
		arf_kind_t;

	// One queued frame request
	typedef struct packed {
		arf_kind_t kind;
		logic [7:0] frameId;
		logic [7:0] nameHi;
		logic [7:0] nameLo;
		logic [7:0] result;
		logic [3:0] dataLen;
		logic [63:0] data;
	} arf_req_t;

	// Serial byte stream toward the host
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} arf_byte_t;
endpackage : arf_pkg
`default_nettype wire

// *** logic/arf_apb_slave.sv ***
// APB slave front: decodes transfers into read/write strobes.
// Assumes a single clock shared with the framer; zero wait states.
`timescale 1ns/1ps
`default_nettype none
module arf_apb_slave (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	output logic pready,
	output logic pslverr,
	output logic wrStb,
	output logic rdStb,
	input wire logic mapped
);
	// ----------------------------------------
	// Access phase decode
	// ----------------------------------------
	// Answer in the first access cycle; nothing to wait on
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;
	assign wrStb = psel & penable & pwrite & mapped;
	assign rdStb = psel & penable & ~pwrite;
	logic unusedClk;
	assign unusedClk = clk & rstn;
endmodule : arf_apb_slave
`default_nettype wire

// *** logic/arf_checksum.sv ***
// Running frame checksum over body bytes (offset 3 up to before checksum).
// Assumes the framer strobes each body byte once, clears at frame start.
`timescale 1ns/1ps
`default_nettype none
module arf_checksum (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic clear,
	input wire logic add,
	input wire logic [7:0] byteIn,
	output logic [7:0] cksum
);
	typedef struct packed {
		logic [7:0] sum;
	} arf_ck_state_t;
	arf_ck_state_t st;
	arf_ck_state_t next_st;

	always_comb begin
		next_st = st;
		if (clear) begin
			next_st.sum = 8'h00;
		end else if (add) begin
			next_st.sum = 8'(st.sum + byteIn);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign cksum = 8'(arf_pkg::ARF_CKSUM_BASE - st.sum);
endmodule : arf_checksum
`default_nettype wire

// *** logic/api_response_framer.sv ***
// API response framer: builds delimited, checksummed frames for the host.
// Assumes APB software posts requests; byte sink gives ready per byte.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module api_response_framer #(
	parameter int DATA_MAX = arf_pkg::ARF_DATA_MAX
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic coordFormed,
	output logic txValid,
	output logic [7:0] txData,
	output logic txLast,
	input wire logic txReady,
	output logic irq
);
	if (DATA_MAX < 1 || DATA_MAX > 8) begin : g_chk
		$error("DATA_MAX must be 1..8");
	end

	typedef struct packed {
		arf_pkg::arf_phase_t phase;
		arf_pkg::arf_req_t req;
		arf_pkg::arf_req_t cur;
		logic pend;
		logic coordPend;
		logic [3:0] idx;
		logic [7:0] len;
		logic [7:0] outByte;
		logic outLast;
		logic outValid;
		logic [arf_pkg::ARF_IRQ_W-1:0] irqStat;
		logic [arf_pkg::ARF_IRQ_W-1:0] irqMask;
		logic [7:0] lastHops;
		logic [1:0] coordSync;
		logic coordPrev;
	} arf_state_t;

	arf_state_t st;
	arf_state_t next_st;
	logic wrStb;
	logic rdStb;
	logic mapped;
	logic ckClear;
	logic ckAdd;
	logic [7:0] ckVal;
	logic [7:0] bodyByte;
	logic [7:0] bodyLen;
	logic take;
	logic [arf_pkg::ARF_IRQ_W-1:0] evt;

	arf_apb_slave u_apb (
		.clk(clk),
		.rstn(rstn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.pslverr(pslverr),
		.wrStb(wrStb),
		.rdStb(rdStb),
		.mapped(mapped)
	);

	arf_checksum u_ck (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.clear(ckClear),
		.add(ckAdd),
		.byteIn(bodyByte),
		.cksum(ckVal)
	);

	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= arf_pkg::ARF_A_ROUTE);
	// Byte leaves when the sink takes it
	assign take = st.outValid & txReady;

	// ----------------------------------------
	// Body byte selection
	// ----------------------------------------
	always_comb begin
		bodyByte = 8'h00;
		case (st.cur.kind)
			arf_pkg::ARF_K_CMD: begin
				case (st.idx)
					4'h0: bodyByte = arf_pkg::ARF_TYPE_CMDRSP;
					4'h1: bodyByte = st.cur.frameId;
					4'h2: bodyByte = st.cur.nameHi;
					4'h3: bodyByte = st.cur.nameLo;
					4'h4: bodyByte = st.cur.result;
					// Read data, byte k from bits 8k up
					default: bodyByte = st.cur.data[8*(st.idx-4'h5) +: 8];
				endcase
			end
			arf_pkg::ARF_K_MODEM: begin
				bodyByte = (st.idx == 4'h0) ? arf_pkg::ARF_TYPE_MODEM
					: st.cur.result;
			end
			default: begin
				bodyByte = (st.idx == 4'h0) ? arf_pkg::ARF_TYPE_TXSTAT
					: st.cur.frameId;
			end
		endcase
	end

	always_comb begin
		case (st.cur.kind)
			arf_pkg::ARF_K_CMD: bodyLen = 8'(arf_pkg::ARF_CMD_HDR
				+ {4'h0, st.cur.dataLen});
			arf_pkg::ARF_K_MODEM: bodyLen = arf_pkg::ARF_MODEM_LEN;
			default: bodyLen = arf_pkg::ARF_TXST_LEN;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		evt = '0;
		ckClear = 1'b0;
		ckAdd = 1'b0;
		next_st.coordSync = {st.coordSync[0], coordFormed};
		next_st.coordPrev = st.coordSync[1];
		if (st.coordSync[1] & ~st.coordPrev) begin
			next_st.coordPend = 1'b1;
		end

		if (wrStb) begin
			case (paddr)
				arf_pkg::ARF_A_CMD: begin
					next_st.req.frameId = pwdata[7:0];
					next_st.req.nameHi = pwdata[15:8];
					next_st.req.nameLo = pwdata[23:16];
					next_st.req.result = pwdata[31:24];
				end
				arf_pkg::ARF_A_DATALO: next_st.req.data[31:0] = pwdata;
				arf_pkg::ARF_A_DATAHI: next_st.req.data[63:32] = pwdata;
				arf_pkg::ARF_A_EVENT: begin
					next_st.req.result = pwdata[7:0];
					next_st.req.frameId = pwdata[7:0];
				end
				arf_pkg::ARF_A_IRQ: next_st.irqStat = st.irqStat
					& ~pwdata[arf_pkg::ARF_IRQ_W-1:0];
				arf_pkg::ARF_A_MASK:
					next_st.irqMask = pwdata[arf_pkg::ARF_IRQ_W-1:0];
				arf_pkg::ARF_A_ROUTE: begin
					next_st.lastHops = pwdata[7:0];
					// Bad hop count is still stored, and flags irq bit 2
					if (pwdata[7:0] == 8'h00
						|| pwdata[7:0] > arf_pkg::ARF_HOPS_MAX) begin
						evt[2] = 1'b1;
					end
				end
				arf_pkg::ARF_A_CTRL: begin
					if (st.pend) begin
						evt[3] = 1'b1;
					end else begin
						next_st.req.kind = arf_pkg::arf_kind_t'(pwdata[1:0]);
						next_st.req.dataLen = (pwdata[7:4] > 4'(DATA_MAX))
							? 4'(DATA_MAX) : pwdata[7:4];
						if (pwdata[1:0] == 2'h0 && st.req.frameId == 8'h00) begin
							evt[1] = 1'b1;
						end else begin
							next_st.pend = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		case (st.phase)
			arf_pkg::ARF_IDLE: begin
				if (st.coordPend) begin
					next_st.cur.kind = arf_pkg::ARF_K_MODEM;
					next_st.cur.result = arf_pkg::ARF_ST_COORD;
					next_st.coordPend = 1'b0;
					next_st.phase = arf_pkg::ARF_DELIMS;
				end else if (st.pend) begin
					next_st.cur = st.req;
					next_st.pend = 1'b0;
					next_st.phase = arf_pkg::ARF_DELIMS;
				end
			end
			arf_pkg::ARF_DELIMS: begin
				next_st.outByte = arf_pkg::ARF_DELIM;
				next_st.outValid = 1'b1;
				next_st.outLast = 1'b0;
				next_st.len = bodyLen;
				ckClear = 1'b1;
				next_st.idx = 4'h0;
				next_st.phase = arf_pkg::ARF_LENH;
			end
			arf_pkg::ARF_LENH: begin
				if (take) begin
					next_st.outByte = 8'h00;
					next_st.phase = arf_pkg::ARF_LENL;
				end
			end
			arf_pkg::ARF_LENL: begin
				if (take) begin
					next_st.outByte = st.len;
					next_st.phase = arf_pkg::ARF_BODY;
				end
			end
			arf_pkg::ARF_BODY: begin
				if (take) begin
					next_st.outByte = bodyByte;
					ckAdd = 1'b1;
					next_st.idx = 4'(st.idx + 4'h1);
					if (8'({4'h0, st.idx} + 8'h01) == st.len) begin
						next_st.phase = arf_pkg::ARF_CKS;
					end
				end
			end
			arf_pkg::ARF_CKS: begin
				if (take) begin
					if (st.outLast) begin
						next_st.outValid = 1'b0;
						next_st.outLast = 1'b0;
						evt[0] = 1'b1;
						next_st.phase = arf_pkg::ARF_IDLE;
					end else begin
						next_st.outByte = ckVal;
						next_st.outLast = 1'b1;
					end
				end
			end
			default: next_st.phase = arf_pkg::ARF_IDLE;
		endcase
		// Set wins over a clear in the same cycle
		next_st.irqStat = next_st.irqStat | evt;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.phase <= arf_pkg::ARF_IDLE;
			st.irqStat <= arf_pkg::ARF_IRQ_RESET;
			st.irqMask <= arf_pkg::ARF_MASK_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Read mux and outputs
	// ----------------------------------------
	always_comb begin
		prdata = 32'h0000_0000;
		if (rdStb) begin
			case (paddr)
				arf_pkg::ARF_A_CMD: prdata = {st.req.result, st.req.nameLo,
					st.req.nameHi, st.req.frameId};
				arf_pkg::ARF_A_DATALO: prdata = st.req.data[31:0];
				arf_pkg::ARF_A_DATAHI: prdata = st.req.data[63:32];
				arf_pkg::ARF_A_STATUS: prdata = {30'h0,
					st.phase != arf_pkg::ARF_IDLE, st.pend};
				arf_pkg::ARF_A_IRQ: prdata = {28'h000_0000, st.irqStat};
				arf_pkg::ARF_A_MASK: prdata = {28'h000_0000, st.irqMask};
				arf_pkg::ARF_A_ROUTE: prdata = {24'h00_0000, st.lastHops};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	assign txValid = st.outValid;
	assign txData = st.outByte;
	assign txLast = st.outLast;
	assign irq = |(st.irqStat & st.irqMask);
endmodule : api_response_framer
`default_nettype wire

// *** tb/arf_checker_sva.sv ***
// Checker for the framer's APB and byte stream ports.
// Bound to api_response_framer; watches its ports only.
`timescale 1ns/1ps
`default_nettype none
module arf_checker #(
	parameter int DATA_MAX = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic txLast,
	input wire logic txReady
);
	logic [7:0] idx;
	logic [7:0] lenReg;
	logic [7:0] sum;
	// Byte position, length and body sum
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idx <= 8'h00;
			lenReg <= 8'h00;
			sum <= 8'h00;
		end else if (txValid && txReady) begin
			idx <= txLast ? 8'h00 : idx + 8'h01;
			lenReg <= (idx == 8'h02) ? txData : lenReg;
			sum <= (txLast || idx < 8'h03) ? 8'h00 : sum + txData;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence sAt(logic [7:0] pos);
		txValid && idx == pos;
	endsequence
	sequence sType(logic [7:0] t);
		sAt(8'h03) ##0 txData == t;
	endsequence
	// ----------------
	// Assertions
	// ----------------
	AST_DELIM: assert property (sAt(8'h00) |-> txData == 8'h7E)
		else $error("no delimiter");
	AST_LENHI: assert property (sAt(8'h01) |-> txData == 8'h00)
		else $error("length high byte");
	AST_LEN: assert property (txValid && txLast |->
		idx == 8'(lenReg + 8'h03))
		else $error("length mismatch");
	AST_CKS: assert property (txValid && txLast |->
		txData == 8'(8'hFF - sum))
		else $error("bad checksum");
	AST_TYPE: assert property (sAt(8'h03) |->
		txData inside {8'h88, 8'h8A, 8'h8B})
		else $error("bad frame type");
	AST_MODEM: assert property (sType(8'h8A) |-> lenReg == 8'h02)
		else $error("modem length");
	AST_CMDLEN: assert property (sType(8'h88) |->
		lenReg >= 8'h05 && lenReg <= 8'(8'h05 + DATA_MAX))
		else $error("reply length");
	AST_HOLD: assert property (txValid && !txReady |=>
		txValid && $stable(txData) && $stable(txLast))
		else $error("byte not held");
	AST_PREADY: assert property (psel && penable |-> pready)
		else $error("wait state");
	AST_SLVERR: assert property (pslverr |-> psel && penable)
		else $error("stray error");
endmodule : arf_checker
bind api_response_framer arf_checker #(.DATA_MAX(DATA_MAX)) uChk (.clk,
	.rstn, .psel, .penable, .pready, .pslverr, .txValid, .txData, .txLast,
	.txReady);
`default_nettype wire

// *** tb/arf_host_model.sv ***
// Host model: takes framer bytes, ready only one cycle in four while slow is high.
// Assumes the framer's clock; any number of frames is taken.
`timescale 1ns/1ps
`default_nettype none
module arf_host_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic slow,
	output logic txReady
);
	logic [1:0] cnt;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 2'h0;
			txReady <= 1'b0;
		end else begin
			cnt <= cnt + 2'h1;
			txReady <= !slow || cnt == 2'h3;
		end
	end
endmodule : arf_host_model
`default_nettype wire

// *** tb/tb.sv ***
// Testbench: APB requests in, frames checked as the host sees them.
// Assumes the host model paces txReady; ce is dropped once.
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [1:0] kind;
		logic [31:0] arg;
		logic [3:0] cnt;
		logic [63:0] data;
		logic [7:0] typ;
		logic [7:0] len;
	} arf_row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic coordFormed = 1'b0;
	logic slow = 1'b0;
	logic ce = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, txValid, txLast, txReady, irq;
	logic [7:0] txData;
	logic [7:0] rxq[$];
	logic [7:0] exq[$];
	logic [7:0] hops[4] = '{8'h00, 8'h01, 8'h28, 8'h29};
	int bad_count = 0;
	int total_checks = 0;
	int frames = 0;
	arf_row_t rows[17] = '{
		'{2'h0, 32'h00444201, 4'h0, 64'h0, 8'h88, 8'h05},
		'{2'h0, 32'h00444E02, 4'h2, 64'hBEEF, 8'h88, 8'h07},
		'{2'h0, 32'h01444203, 4'h0, 64'h0, 8'h88, 8'h05},
		'{2'h0, 32'h02444204, 4'h0, 64'h0, 8'h88, 8'h05},
		'{2'h0, 32'h03444205, 4'h0, 64'h0, 8'h88, 8'h05},
		'{2'h0, 32'h04444206, 4'h0, 64'h0, 8'h88, 8'h05},
		'{2'h0, 32'h00444207, 4'h8, 64'h0123456789ABCDEF, 8'h88, 8'h0D},
		'{2'h1, 32'h00, 4'h0, 64'h0, 8'h8A, 8'h02},
		'{2'h1, 32'h01, 4'h0, 64'h0, 8'h8A, 8'h02},
		'{2'h1, 32'h02, 4'h0, 64'h0, 8'h8A, 8'h02},
		'{2'h1, 32'h03, 4'h0, 64'h0, 8'h8A, 8'h02},
		'{2'h1, 32'h07, 4'h0, 64'h0, 8'h8A, 8'h02},
		'{2'h1, 32'h0D, 4'h0, 64'h0, 8'h8A, 8'h02},
		'{2'h1, 32'h11, 4'h0, 64'h0, 8'h8A, 8'h02},
		'{2'h1, 32'h80, 4'h0, 64'h0, 8'h8A, 8'h02},
		'{2'h1, 32'hC5, 4'h0, 64'h0, 8'h8A, 8'h02},
		'{2'h2, 32'h33, 4'h0, 64'h0, 8'h8B, 8'h02}};

	api_response_framer #(.DATA_MAX(8)) DUT (.clk, .rstn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.coordFormed, .txValid, .txData, .txLast, .txReady, .irq);
	arf_host_model uHost (.clk, .rstn, .slow, .txReady);

	initial begin
		forever #12.5 clk = ~clk;
	end
	initial begin
		#(25 * 20000);
		bad_count++;
		stop_test();
	end
	always @(posedge clk) begin
		if (txValid === 1'b1 && txReady === 1'b1) begin
			rxq.push_back(txData);
			if (txLast === 1'b1) frames++;
		end
	end

	// ----------------
	// Tasks
	// ----------------
	task automatic stop_test();
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chkW
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic chkIrq(input logic e);
		@(negedge clk);
		chkW({31'h0, irq}, {31'h0, e});
	endtask : chkIrq
	task automatic build(input arf_row_t r);
		exq.push_back(r.typ);
		exq.push_back(r.arg[7:0]);
		if (r.kind == 2'h0) begin
			exq.push_back(r.arg[15:8]);
			exq.push_back(r.arg[23:16]);
			exq.push_back(r.arg[31:24]);
			for (int k = 0; k < r.cnt; k++) exq.push_back(r.data[8 * k +: 8]);
		end
	endtask : build
	task automatic checkFrame(input logic [7:0] len);
		logic [7:0] s;
		int n;
		s = 8'h00;
		n = 0;
		while (frames == 0 && n < 500) begin
			@(posedge clk);
			n++;
		end
		foreach (exq[k]) s += exq[k];
		exq.push_front(len);
		exq.push_front(8'h00);
		exq.push_front(8'h7E);
		exq.push_back(8'hFF - s);
		chkW(32'(rxq.size()), 32'(exq.size()));
		foreach (exq[k])
			if (k < rxq.size()) chkW(32'(rxq[k]), 32'(exq[k]));
		rxq.delete();
		exq.delete();
		frames = 0;
	endtask : checkFrame

	// ----------------
	// Sequence
	// ----------------
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			slow <= i[0];
			wr(rows[i].kind == 2'h0 ? arf_pkg::ARF_A_CMD : arf_pkg::ARF_A_EVENT,
				rows[i].arg);
			wr(arf_pkg::ARF_A_DATALO, rows[i].data[31:0]);
			wr(arf_pkg::ARF_A_DATAHI, rows[i].data[63:32]);
			repeat (i == 1 ? 2 : 1) begin
				wr(arf_pkg::ARF_A_CTRL, {24'h0, rows[i].cnt, 2'h0, rows[i].kind});
				build(rows[i]);
				checkFrame(rows[i].len);
			end
		end
		// Third request finds one pending: refused, bit3
		slow <= 1'b1;
		repeat (3) wr(arf_pkg::ARF_A_CTRL, 32'h2);
		repeat (2) begin
			build(rows[16]);
			checkFrame(8'h02);
		end
		apb(1'b0, arf_pkg::ARF_A_IRQ, 32'h0);
		chkW(rd, 32'h9);
		// Frozen block loses a request
		ce <= 1'b0;
		wr(arf_pkg::ARF_A_CTRL, 32'h2);
		repeat (10) @(posedge clk);
		ce <= 1'b1;
		repeat (10) @(posedge clk);
		chkW(32'(rxq.size()), 32'h0);
		coordFormed <= 1'b1;
		exq = '{8'h8A, 8'h06};
		checkFrame(8'h02);
		coordFormed <= 1'b0;
		wr(arf_pkg::ARF_A_IRQ, 32'hF);
		wr(arf_pkg::ARF_A_CMD, 32'h00444200);
		wr(arf_pkg::ARF_A_CTRL, 32'h0);
		// No frame may follow, so a fixed wait
		repeat (40) @(posedge clk);
		chkW(32'(frames), 32'h0);
		chkIrq(1'b0);
		wr(arf_pkg::ARF_A_MASK, 32'h2);
		chkIrq(1'b1);
		apb(1'b0, arf_pkg::ARF_A_IRQ, 32'h0);
		chkW(rd, 32'h2);
		wr(arf_pkg::ARF_A_IRQ, 32'h2);
		chkIrq(1'b0);
		// Hop order is the host's duty; counts checked
		for (int h = 0; h < 4; h++) begin
			wr(arf_pkg::ARF_A_ROUTE, {24'h0, hops[h]});
			apb(1'b0, arf_pkg::ARF_A_IRQ, 32'h0);
			chkW(rd & 32'h4, (hops[h] == 8'h00 || hops[h] > 8'h28)
				? 32'h4 : 32'h0);
			wr(arf_pkg::ARF_A_IRQ, 32'h4);
		end
		apb(1'b0, 8'h24, 32'h0);
		chkW({31'h0, err}, 32'h1);
		// Reset lands in the middle of a frame
		wr(arf_pkg::ARF_A_EVENT, 32'h2);
		wr(arf_pkg::ARF_A_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chkW({31'h0, txValid}, 32'h1);
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		chkW({31'h0, txValid}, 32'h0);
		apb(1'b0, arf_pkg::ARF_A_IRQ, 32'h0);
		chkW(rd, 32'(arf_pkg::ARF_IRQ_RESET));
		apb(1'b0, arf_pkg::ARF_A_MASK, 32'h0);
		chkW(rd, 32'(arf_pkg::ARF_MASK_RESET));
		stop_test();
	end
endmodule : tb
`default_nettype wire
